// file: core/timer_map.vh
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
// ==================================================
// register byte addresses
`define MODE_CTRL_ADDR 16'hff48
`define COMPARE_ADDR 16'hff4c
`define COUNT_ADDR 16'hff50
`define CAPTURE_ADDR 16'hff54
`define PORT_DATA_ADDR 16'hff58
// ==================================================
// reset values
`define MODE_CTRL_RESET 8'h00
`define COMPARE_RESET 16'hffff
`define COUNT_RESET 16'h0000
// ==================================================
// mode control field positions
`define OUT_LEVEL_BIT 7
`define OVERFLOW_BIT 6
`define CAP_EDGE_HI 5
`define CAP_EDGE_LO 4
`define INVERT_EN_BIT 3
`define CLK_SEL_HI 2
`define CLK_SEL_LO 1
`define OUT_EN_BIT 0
// ==================================================
// encodings and divider ratios
`define CAP_OFF 2'h0
`define CAP_RISE 2'h1
`define CAP_FALL 2'h2
`define CAP_BOTH 2'h3
`define CLK_DIV4 2'h0
`define CLK_DIV64 2'h1
`define CLK_DIV16 2'h2
`define DIV4_LAST 6'h03
`define DIV16_LAST 6'h0f
`define DIV64_LAST 6'h3f
// ==================================================
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: core/free_running_timer.v
`include "timer_map.vh"

module free_running_timer #(
	parameter CNT_W = 16
) (
	input wire sys_clk,
	input wire rst,
	input wire [15:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [15:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire capturePin,
	output reg timerOutPin,
	output reg matchIrq
);

	// ==================================================
	// state
	reg [CNT_W-1:0] countReg_q;
	reg [CNT_W-1:0] compareReg_q;
	reg [CNT_W-1:0] captureReg_q;
	reg [CNT_W-1:0] readBuf_q;
	reg [7:0] modeCtrl_q;
	reg portData_q;
	reg [5:0] prescale_q;
	reg capSync1_q;
	reg capSync2_q;
	reg capPrev_q;
	reg capHit_q;
	reg [15:0] awAddr_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	reg awHave_q;
	reg wHave_q;

	wire outLevel = modeCtrl_q[`OUT_LEVEL_BIT];
	wire invertEn = modeCtrl_q[`INVERT_EN_BIT];
	wire outEn = modeCtrl_q[`OUT_EN_BIT];
	wire [1:0] capEdgeSel = modeCtrl_q[`CAP_EDGE_HI:`CAP_EDGE_LO];
	wire [1:0] clkSel = modeCtrl_q[`CLK_SEL_HI:`CLK_SEL_LO];

	// ==================================================
	// prescaler: one-cycle count enable at the selected division
	reg [5:0] preLast;
	always @* begin
		case (clkSel)
			`CLK_DIV4: preLast = `DIV4_LAST;
			`CLK_DIV64: preLast = `DIV64_LAST;
			`CLK_DIV16: preLast = `DIV16_LAST;
			default: preLast = `DIV4_LAST; // prohibited code falls back to fastest rate
		endcase
	end
	// masking keeps a shortened ratio from stalling when software lowers the division
	wire countTick = ((prescale_q & preLast) == preLast);

	// the divider is not restarted on a select change, so the first period may be short
	always @(posedge sys_clk) begin
		if (rst) begin
			prescale_q <= 6'h00;
		end else begin
			prescale_q <= prescale_q + 6'h01;
		end
	end

	// ==================================================
	// free-running counter, never cleared by a match
	// count enable comes from the shared prescaler, one pulse per selected period
	// stop mode is outside this block; an oscillator restart leaves the count arbitrary
	always @(posedge sys_clk) begin
		if (rst) begin
			countReg_q <= `COUNT_RESET;
		end else if (countTick) begin
			countReg_q <= countReg_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	wire wrapNow = countTick && (&countReg_q);
	// match flagged once per count value, on the cycle it is entered or compare changes
	wire matchNow = (countReg_q == compareReg_q);
	reg matchPrev_q;
	wire matchEvent = matchNow && !matchPrev_q;

	// ==================================================
	// capture pin synchroniser and edge detector
	always @(posedge sys_clk) begin
		if (rst) begin
			capSync1_q <= 1'b0;
			capSync2_q <= 1'b0;
			capPrev_q <= 1'b0;
		end else begin
			capSync1_q <= capturePin;
			capSync2_q <= capSync1_q;
			capPrev_q <= capSync2_q;
		end
	end

	reg capEdge;
	always @* begin
		case (capEdgeSel)
			`CAP_RISE: capEdge = capSync2_q && !capPrev_q;
			`CAP_FALL: capEdge = !capSync2_q && capPrev_q;
			`CAP_BOTH: capEdge = capSync2_q ^ capPrev_q;
			default: capEdge = 1'b0;
		endcase
	end

	// capture one cycle after the edge: well inside the two-clock window
	// capture register is never reset: it is undefined until the first capture edge
	always @(posedge sys_clk) begin
		if (rst) begin
			capHit_q <= 1'b0;
		end else begin
			capHit_q <= capEdge;
		end
		if (capHit_q) begin
			captureReg_q <= countReg_q;
		end
	end

	// ==================================================
	// bus write path
	// a write fires once address and data are both held and the last answer is gone
	wire wrFire = awHave_q && wHave_q && !s_axi_bvalid;
	// an answer still waiting for bready keeps both readies low
	wire wrAnswerHeld = s_axi_bvalid && !s_axi_bready;
	wire [15:0] wrAddr = awAddr_q;

	function [7:0] mergeByte;
		input [7:0] old;
		input [7:0] nw;
		input en;
		begin
			mergeByte = en ? nw : old;
		end
	endfunction

	always @(posedge sys_clk) begin
		if (rst) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= 16'h0000;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			// readies drop after each take, stay low until the held write fires, and stay low while the answer waits
			s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready) && !wrAnswerHeld;
			s_axi_wready <= !wHave_q && !(s_axi_wvalid && s_axi_wready) && !wrAnswerHeld;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrFire) begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (wrAddr)
					`MODE_CTRL_ADDR, `COMPARE_ADDR, `COUNT_ADDR,
					`CAPTURE_ADDR, `PORT_DATA_ADDR: s_axi_bresp <= `RESP_OKAY;
					default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// byte lane 0 carries the whole mode register; other lanes are ignored
	wire modeWr = wrFire && (wrAddr == `MODE_CTRL_ADDR) && wStrb_q[0];
	// compare takes each byte lane on its own, so byte writes work
	wire cmpWr = wrFire && (wrAddr == `COMPARE_ADDR);
	wire [7:0] modeWrByte = wData_q[7:0];

	// ==================================================
	// compare, port latch and mode control registers
	always @(posedge sys_clk) begin
		if (rst) begin
			compareReg_q <= `COMPARE_RESET;
			portData_q <= 1'b0;
			modeCtrl_q <= `MODE_CTRL_RESET;
			matchPrev_q <= 1'b0;
		end else begin
			matchPrev_q <= matchNow;
			if (cmpWr) begin
				compareReg_q[7:0] <= mergeByte(compareReg_q[7:0], wData_q[7:0], wStrb_q[0]);
				compareReg_q[15:8] <= mergeByte(compareReg_q[15:8], wData_q[15:8], wStrb_q[1]);
			end
			// port latch bit drives the pin while the timer output is disabled
			if (wrFire && (wrAddr == `PORT_DATA_ADDR) && wStrb_q[0]) begin
				portData_q <= wData_q[0];
			end
			if (modeWr) begin
				// level bit is read-only; bits 5..0 take the written byte
				modeCtrl_q[5:0] <= modeWrByte[5:0];
			end
			// overflow: wrap sets, software zero clears, set wins
			if (wrapNow) begin
				modeCtrl_q[`OVERFLOW_BIT] <= 1'b1;
			end else if (modeWr && !modeWrByte[`OVERFLOW_BIT]) begin
				modeCtrl_q[`OVERFLOW_BIT] <= 1'b0;
			end
			// output level starts low while disabled, toggles per match when inverting
			if (!outEn) begin
				modeCtrl_q[`OUT_LEVEL_BIT] <= 1'b0;
			end else if (matchEvent && invertEn) begin
				modeCtrl_q[`OUT_LEVEL_BIT] <= !outLevel;
			end
		end
	end

	// ==================================================
	// pin and interrupt outputs, registered
	// both outputs come straight from flip-flops, one cycle after the match event and the level bit, or the port latch while the output is disabled
	always @(posedge sys_clk) begin
		if (rst) begin
			timerOutPin <= 1'b0;
			matchIrq <= 1'b0;
		end else begin
			timerOutPin <= outEn ? outLevel : portData_q;
			matchIrq <= matchEvent;
		end
	end

	// ==================================================
	// bus read path; counter read latches the read buffer
	always @(posedge sys_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
			readBuf_q <= `COUNT_RESET;
		end else begin
			// one read at a time: no address is taken while the answer stands
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			// buffer follows the count while idle and holds it while an answer stands
			if (!s_axi_rvalid) begin
				readBuf_q <= countReg_q;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				// unused upper bits and unmapped addresses read as zero
				s_axi_rdata <= 32'h00000000;
				case (s_axi_araddr)
					`MODE_CTRL_ADDR: s_axi_rdata[7:0] <= modeCtrl_q;
					`COMPARE_ADDR: s_axi_rdata[15:0] <= compareReg_q;
					`COUNT_ADDR: begin
						// both bytes come from one buffered word, so they always agree
						s_axi_rdata[15:0] <= readBuf_q;
					end
					`CAPTURE_ADDR: s_axi_rdata[15:0] <= captureReg_q;
					`PORT_DATA_ADDR: s_axi_rdata[0] <= portData_q;
					default: s_axi_rresp <= `RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// file: dv/free_running_timer_properties.sv
module free_running_timer_properties (
	input logic sys_clk,
	input logic rst,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic timerOutPin,
	input logic matchIrq
);
	// ==========
	// bus and event checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// reset itself is the cause here, so this one is never disabled
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> !matchIrq && !timerOutPin)
		else $error("outputs active after reset");
	// a match is a single pulse; the count needs four clocks to move on
	a_irq_pulse: assert property (matchIrq |=> !matchIrq [*3])
		else $error("match pulse too long");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
		else $error("read answer dropped");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken during answer");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while pending");
endmodule

bind free_running_timer free_running_timer_properties u_free_running_timer_properties (
	.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .timerOutPin, .matchIrq
);

// file: dv/capture_source.sv
module capture_source (
	input logic sys_clk,
	input logic lvl,
	output logic capturePin
);
	timeunit 1ns;
	timeprecision 1ps;
	// outside source: follows the requested level one clock later, like a synchronous pin
	initial capturePin = 1'b0;
	always @(posedge sys_clk) capturePin <= lvl;
endmodule

// file: dv/tb.sv
`include "timer_map.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, rst = 1, lvl = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, capturePin, timerOutPin, matchIrq, hit;
	logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0, v;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv, p, q, c0, c1;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, bQ[$];
	logic [33:0] eQ[$], mQ[$];
	int i, n, d, e, n_mismatch = 0, compares = 0;
	always #4 sys_clk = ~sys_clk;
	free_running_timer u_free_running_timer (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capturePin, .timerOutPin, .matchIrq);
	capture_source u_capture_source (.sys_clk, .lvl, .capturePin);
	// ==========
	// bus master; bready and rready go up with the request and stay up until the answer
	task wr(input logic [15:0] a, input logic [31:0] dt, input logic [3:0] s, input logic [1:0] r);
		bQ.push_back(r);
		@(posedge sys_clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, dt, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		forever begin
			@(posedge sys_clk);
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
	endtask
	task rd(input logic [15:0] a, input logic [33:0] ex, input logic [33:0] m, output logic [31:0] r);
		eQ.push_back(ex & m);
		mQ.push_back(m);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		forever begin
			@(posedge sys_clk);
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		r = s_axi_rdata;
		s_axi_rready <= 0;
	endtask
	// monitor: oldest note against each answer as it is handed over
	always @(posedge sys_clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			`CHK({s_axi_rresp, s_axi_rdata} & mQ[0], eQ[0])
			void'(eQ.pop_front());
			void'(mQ.pop_front());
		end
		if (s_axi_bvalid && s_axi_bready) begin
			`CHK(s_axi_bresp, bQ[0])
			void'(bQ.pop_front());
		end
	end
	task give_verdict;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// whole run needs under 3k clocks
	initial begin
		#400000;
		n_mismatch++;
		give_verdict;
	end
	// ==========
	// scenarios
	initial begin
		void'($urandom(59));
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		rd(`MODE_CTRL_ADDR, 0, '1, rv);
		rd(`COMPARE_ADDR, 34'hffff, '1, rv);
		rd(`COUNT_ADDR, 0, 34'h3ffffff00, rv);
		// a write to the counter is answered but leaves the count running from zero
		wr(`COUNT_ADDR, 32'hffff, 4'h3, `RESP_OKAY);
		rd(`COUNT_ADDR, 0, 34'h3ffffff00, rv);
		rd(16'hff60, {`RESP_SLVERR, 32'h0}, '1, rv);
		wr(16'hff60, 0, 4'hf, `RESP_SLVERR);
		// boundaries and random values, inversion off while rewriting
		for (i = 0; i < 4; i++) begin
			v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
			wr(`COMPARE_ADDR, {16'h0, v}, 4'h3, `RESP_OKAY);
			rd(`COMPARE_ADDR, {18'h0, v}, '1, rv);
		end
		wr(`COMPARE_ADDR, 32'hab, 4'h1, `RESP_OKAY);
		rd(`COMPARE_ADDR, {18'h0, v[15:8], 8'hab}, '1, rv);
		wr(`MODE_CTRL_ADDR, 32'hb5, 4'h1, `RESP_OKAY);
		wr(`MODE_CTRL_ADDR, 32'h0, 4'h0, `RESP_OKAY);
		rd(`MODE_CTRL_ADDR, 34'h35, '1, rv);
		// count rate per clock select code: 640 clocks gives 160, 10, 40 ticks
		for (i = 0; i < 3; i++) begin
			wr(`MODE_CTRL_ADDR, i << 1, 4'h1, `RESP_OKAY);
			rd(`COUNT_ADDR, 0, 0, c0);
			repeat (640) @(posedge sys_clk);
			rd(`COUNT_ADDR, 0, 0, c1);
			d = 16'(c1[15:0] - c0[15:0]);
			e = 640 / ((i == 0) ? 4 : (i == 1) ? 64 : 16);
			`CHK(d >= e - 1 && d <= e + 1, 1'b1)
		end
		// compare match with output inversion
		// port latch high first, so only the enabled timer level can pull the pin low
		wr(`PORT_DATA_ADDR, 32'h1, 4'h1, `RESP_OKAY);
		wr(`MODE_CTRL_ADDR, 32'h01, 4'h1, `RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		`CHK(timerOutPin, 1'b0)
		rd(`COUNT_ADDR, 0, 0, c0);
		v = c0[15:0] + 16'd40;
		wr(`COMPARE_ADDR, {16'h0, v}, 4'h3, `RESP_OKAY);
		wr(`MODE_CTRL_ADDR, 32'h09, 4'h1, `RESP_OKAY);
		n = 0;
		while (matchIrq !== 1'b1 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK(matchIrq, 1'b1)
		repeat (3) @(posedge sys_clk);
		`CHK(timerOutPin, 1'b1)
		rd(`COUNT_ADDR, 0, 0, c1);
		`CHK(16'(c1[15:0] - v) < 16'h8, 1'b1)
		rd(`MODE_CTRL_ADDR, 34'h89, '1, rv);
		wr(`MODE_CTRL_ADDR, 32'h08, 4'h1, `RESP_OKAY);
		wr(`PORT_DATA_ADDR, 32'h1, 4'h1, `RESP_OKAY);
		rd(`MODE_CTRL_ADDR, 34'h08, '1, rv);
		`CHK(timerOutPin, 1'b1)
		wr(`PORT_DATA_ADDR, 32'h0, 4'h1, `RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		`CHK(timerOutPin, 1'b0)
		// every edge code against a rising and a falling pin edge
		for (i = 0; i < 8; i++) begin
			wr(`MODE_CTRL_ADDR, (i >> 1) << 4, 4'h1, `RESP_OKAY);
			rd(`CAPTURE_ADDR, 0, 0, p);
			rd(`COUNT_ADDR, 0, 0, c0);
			lvl <= ~lvl;
			repeat (8) @(posedge sys_clk);
			rd(`CAPTURE_ADDR, 0, 0, q);
			hit = i[0] ? i[2] : i[1];
			if (hit)
				`CHK(16'(q[15:0] - c0[15:0]) <= 16'h4, 1'b1)
			else
				`CHK(q, p)
		end
		give_verdict;
	end
endmodule
